// ---- ddsi_pkg.sv ----
package ddsi_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] DDSI_OFF_CTRL = 8'h00;
  localparam logic [7:0] DDSI_OFF_STEP = 8'h04;
  localparam logic [7:0] DDSI_OFF_DSTAT = 8'h08;
  localparam logic [7:0] DDSI_OFF_ISTAT = 8'h0C;
  localparam logic [7:0] DDSI_OFF_IMASK = 8'h10;
  localparam logic [7:0] DDSI_OFF_DATA = 8'h14;
  // ==========================================================================
  // Control register fields
  localparam int DDSI_CTRL_HEAD_LSB = 0;
  localparam int DDSI_HEAD_W = 3;
  localparam int DDSI_CTRL_WREN = 4;
  localparam int DDSI_CTRL_LOWCUR = 5;
  localparam int DDSI_CTRL_INIT = 6;
  localparam int DDSI_CTRL_W = 7;
  localparam logic [6:0] DDSI_CTRL_RST = 7'h00;
  // Step register fields: count in low byte, direction bit 8 (1 = toward spindle)
  localparam int DDSI_STEP_CNT_W = 8;
  localparam int DDSI_STEP_DIR = 8;
  // Highest head number that can be addressed (four heads)
  localparam logic [2:0] DDSI_HEAD_MAX = 3'h3;
  // ==========================================================================
  // Status / interrupt bits
  localparam int DDSI_EV_STEPDONE = 0;
  localparam int DDSI_EV_SEEKDONE = 1;
  localparam int DDSI_EV_FAULT = 2;
  localparam int DDSI_EV_NOTREADY = 3;
  localparam int DDSI_EV_W = 4;
  // ==========================================================================
  // Timing
  localparam int DDSI_CLK_HZ = 20_000_000;
  localparam int DDSI_STEP_LOW_NS = 1000;
  localparam int DDSI_STEP_GAP_NS = 3000;
  localparam int DDSI_STEP_LOW_CYC = (DDSI_STEP_LOW_NS * (DDSI_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DDSI_STEP_GAP_CYC = (DDSI_STEP_GAP_NS * (DDSI_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DDSI_TMR_W = 8;
  localparam logic [1:0] DDSI_HTRANS_NONSEQ = 2'b10;
  localparam int DDSI_BUF_DEPTH = 512;

  typedef enum logic [1:0] {
    DDSI_ST_IDLE,
    DDSI_ST_LOW,
    DDSI_ST_GAP
  } ddsi_step_e;
endpackage : ddsi_pkg

// ---- ddsi_top.sv ----
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module ddsi_top
  import ddsi_pkg::*;
#(
  parameter int DEPTH = DDSI_BUF_DEPTH
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Host-side initialize line, active low
  input wire logic i_host_init_n,
  // Interrupt
  output logic o_irq,
  // Drive outputs, all active low
  output logic o_low_write_current_n,
  output logic o_head_addr_bit0_n,
  output logic o_head_addr_bit1_n,
  output logic o_head_addr_bit2_n,
  output logic o_write_gate_n,
  output logic o_direction_n,
  output logic o_step_n,
  // Drive inputs, all active low
  input wire logic i_seek_done_n,
  input wire logic i_outer_track_n,
  input wire logic i_ready_n,
  input wire logic i_write_fault_n
);

  // Pointer width follows the buffer depth, so a smaller buffer costs no spare bits
  localparam int AW = $clog2(DEPTH);

  // Timing of the whole block rests on the one system clock. Every drive pin comes
  // in through three flops; a level is only taken once the second and third flop
  // agree, so a single-cycle glitch on the cable never reaches the sequencer.
  // The price is about four cycles of latency on every drive status change,
  // which is far below any mechanical time of the drive and so costs nothing.
  // Outputs towards the drive are all active low and idle high after reset.

  // ==========================================================================
  // State
  // All state lives in one packed struct: the comb process fills s_d from s_q
  // and a single clocked process registers it. Synchroniser stages, filtered
  // levels, the register file, the step sequencer and the bus data phase are
  // kept together so that reset can reach every field.
  // The sector buffer contents are the one exception and sit in their own array.
  typedef struct packed {
    logic [2:0] sync_seek;
    logic [2:0] sync_trk0;
    logic [2:0] sync_rdy;
    logic [2:0] sync_flt;
    logic [2:0] sync_init;
    logic seek_f;
    logic trk0_f;
    logic rdy_f;
    logic flt_f;
    logic [DDSI_CTRL_W-1:0] ctrl;
    logic dir_in;
    logic [DDSI_STEP_CNT_W-1:0] steps;
    logic [DDSI_TMR_W-1:0] tmr;
    ddsi_step_e st;
    logic [DDSI_EV_W-1:0] istat;
    logic [DDSI_EV_W-1:0] imask;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic seek_wait;
  } ddsi_state_s;

  ddsi_state_s s_q;
  ddsi_state_s s_d;
  logic [7:0] buf_mem [DEPTH];
  logic buf_we;
  logic [7:0] buf_rd;

  // Filtered level: changes only when second and third stages agree
  function automatic logic filt(input logic [2:0] sh, input logic cur);
    filt = (sh[1] == sh[2]) ? sh[1] : cur;
  endfunction : filt

  // ==========================================================================
  // Derived conditions
  logic drive_ok;
  logic write_allowed;
  logic a_phase;
  // The drive counts as ready only when both ready and seek complete are low
  assign drive_ok = ~s_q.rdy_f & ~s_q.seek_f;
  // Writing needs settled heads, a ready drive, no fault and no stepping.
  // A pending step count already drops the gate, so the gate is high in the
  // cycle before the first pulse too and never overlaps intended head motion.
  // Filtered fault is high while the drive reports no fault.
  assign write_allowed = s_q.ctrl[DDSI_CTRL_WREN] & drive_ok & s_q.flt_f
    & (s_q.st == DDSI_ST_IDLE) & (s_q.steps == '0);
  // Address phase of an AHB-Lite transfer; only NONSEQ singles are decoded
  assign a_phase = i_hsel & i_hready & (i_htrans == DDSI_HTRANS_NONSEQ);

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    buf_we = 1'b0;
    // Shift every drive pin and the host initialize line through three flops.
    // Only the second and third stages and the filtered level are read by the logic below;
    // the first stage exists purely to let a metastable sample settle.
    s_d.sync_seek = {s_q.sync_seek[1:0], i_seek_done_n};
    s_d.sync_trk0 = {s_q.sync_trk0[1:0], i_outer_track_n};
    s_d.sync_rdy = {s_q.sync_rdy[1:0], i_ready_n};
    s_d.sync_flt = {s_q.sync_flt[1:0], i_write_fault_n};
    s_d.sync_init = {s_q.sync_init[1:0], i_host_init_n};
    s_d.seek_f = filt(s_q.sync_seek, s_q.seek_f);
    s_d.trk0_f = filt(s_q.sync_trk0, s_q.trk0_f);
    s_d.rdy_f = filt(s_q.sync_rdy, s_q.rdy_f);
    s_d.flt_f = filt(s_q.sync_flt, s_q.flt_f);

    // Events: set wins over a clear written in the same cycle.
    // A fault is counted on its falling edge and a lost ready on its rising
    // edge, so a level that stays bad raises the event only once.
    if (s_q.flt_f & ~s_d.flt_f) begin
      s_d.istat[DDSI_EV_FAULT] = 1'b1;
    end
    if (~s_q.rdy_f & s_d.rdy_f) begin
      s_d.istat[DDSI_EV_NOTREADY] = 1'b1;
    end
    // Seek done: after steps, seek complete goes low again
    if (s_q.seek_wait & ~s_q.seek_f & (s_q.st == DDSI_ST_IDLE)) begin
      s_d.seek_wait = 1'b0;
      s_d.istat[DDSI_EV_SEEKDONE] = 1'b1;
    end

    // Step sequencer: direction frozen for the whole sequence.
    // Each pulse is a fixed low time followed by a fixed recovery gap; the
    // count decrements at the end of the low time. Losing ready or seeing a
    // fault stops the sequence at the next gap end, and the remaining count
    // is dropped, so software must re-issue the seek after recovery.
    unique case (s_q.st)
      DDSI_ST_IDLE: begin
        if ((s_q.steps != '0) & drive_ok & s_q.flt_f) begin
          s_d.st = DDSI_ST_LOW;
          s_d.tmr = DDSI_TMR_W'(DDSI_STEP_LOW_CYC - 1);
        end
      end
      DDSI_ST_LOW: begin
        s_d.tmr = s_q.tmr - 1'b1;
        if (s_q.tmr == '0) begin
          s_d.st = DDSI_ST_GAP;
          s_d.steps = s_q.steps - 1'b1;
          s_d.tmr = DDSI_TMR_W'(DDSI_STEP_GAP_CYC - 1);
        end
      end
      DDSI_ST_GAP: begin
        s_d.tmr = s_q.tmr - 1'b1;
        if (s_q.tmr == '0) begin
          if ((s_q.steps != '0) & ~s_q.rdy_f & s_q.flt_f) begin
            s_d.st = DDSI_ST_LOW;
            s_d.tmr = DDSI_TMR_W'(DDSI_STEP_LOW_CYC - 1);
          end else begin
            s_d.st = DDSI_ST_IDLE;
            s_d.steps = '0;
            s_d.seek_wait = 1'b1;
            s_d.istat[DDSI_EV_STEPDONE] = 1'b1;
          end
        end
      end
    endcase

    // AHB data phase: reads answered with data registered at address phase.
    // The slave never stalls, so read data is fetched on the address edge and
    // stands in the data phase; it then holds until the next read.
    // Writes are remembered here and applied when hwdata stands, one edge on.
    s_d.dp_act = a_phase;
    s_d.dp_wr = i_hwrite;
    s_d.dp_addr = i_haddr;
    if (a_phase & ~i_hwrite) begin
      unique case (i_haddr)
        DDSI_OFF_CTRL: begin
          s_d.rdata = 32'(s_q.ctrl);
        end
        DDSI_OFF_STEP: begin
          s_d.rdata = 32'({s_q.dir_in, s_q.steps});
        end
        // Drive status shown active high: fault, ready, outer track, settled
        DDSI_OFF_DSTAT: begin
          s_d.rdata = 32'({~s_q.flt_f, ~s_q.rdy_f, ~s_q.trk0_f, ~s_q.seek_f});
        end
        DDSI_OFF_ISTAT: begin
          s_d.rdata = 32'(s_q.istat);
        end
        DDSI_OFF_IMASK: begin
          s_d.rdata = 32'(s_q.imask);
        end
        // Each buffer read advances the read pointer, wrapping at the depth
        DDSI_OFF_DATA: begin
          s_d.rdata = 32'(buf_rd);
          s_d.rptr = s_q.rptr + 1'b1;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (s_q.dp_act & s_q.dp_wr) begin
      unique case (s_q.dp_addr)
        DDSI_OFF_CTRL: begin
          s_d.ctrl = i_hwdata[DDSI_CTRL_W-1:0];
          // Heads beyond the fourth are clamped rather than selected
          if (i_hwdata[DDSI_CTRL_HEAD_LSB +: DDSI_HEAD_W] > DDSI_HEAD_MAX) begin
            s_d.ctrl[DDSI_CTRL_HEAD_LSB +: DDSI_HEAD_W] = DDSI_HEAD_MAX;
          end
        end
        DDSI_OFF_STEP: begin
          // A new count is ignored while a sequence runs, so direction cannot change
          if (s_q.st == DDSI_ST_IDLE) begin
            s_d.steps = i_hwdata[DDSI_STEP_CNT_W-1:0];
            s_d.dir_in = i_hwdata[DDSI_STEP_DIR];
          end
        end
        // Write one to clear; a bit raised in this very cycle survives the clear
        DDSI_OFF_ISTAT: begin
          s_d.istat = s_d.istat & ~i_hwdata[DDSI_EV_W-1:0] | (s_d.istat & ~s_q.istat);
        end
        DDSI_OFF_IMASK: begin
          s_d.imask = i_hwdata[DDSI_EV_W-1:0];
        end
        // Buffer byte sits in the low lane; the write pointer wraps at the depth
        DDSI_OFF_DATA: begin
          buf_we = 1'b1;
          s_d.wptr = s_q.wptr + 1'b1;
        end
        default: ;
      endcase
    end

    // Initialize: from the pin or the control bit, all registers to initial state.
    // It is placed last so that it overrides any bus write or event of the
    // same cycle, except that a data write still stores its byte in the buffer
    // at the old write pointer; it acts for as long as the line is held low.
    // Synchronisers and filtered levels are left alone: they mirror the pins.
    // Buffer contents are not cleared, only the two pointers.
    if ((s_q.sync_init[1] == s_q.sync_init[2]) & ~s_q.sync_init[2]
        | s_q.ctrl[DDSI_CTRL_INIT]) begin
      s_d.ctrl = DDSI_CTRL_RST;
      s_d.steps = '0;
      s_d.dir_in = 1'b0;
      s_d.st = DDSI_ST_IDLE;
      s_d.tmr = '0;
      s_d.istat = '0;
      s_d.imask = '0;
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.seek_wait = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // Synchroniser stages and filtered levels reset high, the idle level of the
  // active-low pins, so no false edge and no false event follows reset.
  // Everything else starts at zero, which leaves every drive output inactive.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.sync_seek <= 3'h7;
      s_q.sync_trk0 <= 3'h7;
      s_q.sync_rdy <= 3'h7;
      s_q.sync_flt <= 3'h7;
      s_q.sync_init <= 3'h7;
      s_q.seek_f <= 1'b1;
      s_q.trk0_f <= 1'b1;
      s_q.rdy_f <= 1'b1;
      s_q.flt_f <= 1'b1;
      s_q.st <= DDSI_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Sector buffer storage, no reset needed for contents.
  // Reads are asynchronous from the array; a block memory with a registered
  // read would need the read to be fetched one cycle earlier.
  always_ff @(posedge i_sys_clk) begin
    if (buf_we) begin
      buf_mem[s_q.wptr] <= i_hwdata[7:0];
    end
  end
  assign buf_rd = buf_mem[s_q.rptr];

  // ==========================================================================
  // Outputs
  // Bus answer: zero wait states and always OKAY
  assign o_hrdata = s_q.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_irq = |(s_q.istat & s_q.imask);
  // Write gate low only when writing allowed; high whenever heads may move
  assign o_write_gate_n = ~write_allowed;
  assign o_low_write_current_n = ~(s_q.ctrl[DDSI_CTRL_LOWCUR] & write_allowed);
  // Head address in inverted binary; the clamp on write keeps the top bit clear,
  // so only the four addressable heads can ever be presented to the drive
  assign o_head_addr_bit0_n = ~s_q.ctrl[DDSI_CTRL_HEAD_LSB];
  assign o_head_addr_bit1_n = ~s_q.ctrl[DDSI_CTRL_HEAD_LSB + 1];
  assign o_head_addr_bit2_n = ~s_q.ctrl[DDSI_CTRL_HEAD_LSB + 2];
  // Direction pin low means toward spindle
  assign o_direction_n = ~s_q.dir_in;
  assign o_step_n = ~(s_q.st == DDSI_ST_LOW);

  // Transfer size is not checked: only whole-word singles are supported
  logic unused_ok;
  assign unused_ok = (|i_hsize) | (|i_hwdata[31:9]);
endmodule : ddsi_top

// ---- ddsi_props.sv ----
`timescale 1ns/1ps
// ====================
// Drive-side checker
module ddsi_props (
  // Clock, reset and bus answer
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Drive pins
  input wire logic o_low_write_current_n,
  input wire logic o_head_addr_bit2_n,
  input wire logic o_write_gate_n,
  input wire logic o_direction_n,
  input wire logic o_step_n,
  input wire logic i_seek_done_n,
  input wire logic i_ready_n,
  input wire logic i_write_fault_n
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // Pulse shape: full low width, then a recovery gap
  sequence low_then_high;
    ##19 !o_step_n ##1 o_step_n;
  endsequence
  sequence gap_hold;
    o_step_n [*8];
  endsequence
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  reset_idle_a: assert property ($fell(i_reset) |-> o_step_n && o_write_gate_n)
    else $error("drive outputs active after reset");
  low_cur_a: assert property (!o_low_write_current_n |-> !o_write_gate_n)
    else $error("low current without write gate");
  head_range_a: assert property (o_head_addr_bit2_n)
    else $error("head above three selected");
  // Eight cycles covers the input filter; the gate follows the filtered levels without a register
  gate_seek_a: assert property (i_seek_done_n [*8] |-> o_write_gate_n)
    else $error("write gate while heads unsettled");
  gate_ready_a: assert property ((i_ready_n || !i_write_fault_n) [*8] |-> o_write_gate_n)
    else $error("write gate while drive not ready");
  step_gate_a: assert property (!o_step_n |-> o_write_gate_n)
    else $error("step pulse with write gate on");
  dir_hold_a: assert property (!o_step_n |-> $stable(o_direction_n))
    else $error("direction moved during step");
  step_width_a: assert property ($fell(o_step_n) |-> low_then_high)
    else $error("step pulse width wrong");
  step_gap_a: assert property ($rose(o_step_n) |-> gap_hold)
    else $error("step gap too short");
endmodule : ddsi_props
bind ddsi_top ddsi_props i_ddsi_props (.*);

// ---- ddsi_drive_model.sv ----
`timescale 1ns/1ps
// ====================
// Behavioural drive: track counter, settle timer, latched fault
module ddsi_drive_model #(
  parameter int SETTLE = 10
) (
  // Clock and controller pins
  input wire logic i_sys_clk,
  input wire logic i_step_n,
  input wire logic i_dir_n,
  // Bench controls
  input wire logic i_bad_supply,
  input wire logic i_power_cycle,
  input wire logic i_not_ready,
  // Drive status pins, active low
  output logic o_seek_done_n,
  output logic o_outer_track_n,
  output logic o_ready_n,
  output logic o_write_fault_n
);
  int trk = 0;
  int settle = 0;
  logic step_q = 1'b1;
  logic fault_q = 1'b0;
  // A latched fault or lost ready blocks all head motion
  always @(posedge i_sys_clk) begin
    step_q <= i_step_n;
    if (i_power_cycle) fault_q <= 1'b0;
    else if (i_bad_supply) fault_q <= 1'b1;
    if (step_q && !i_step_n && !fault_q && !i_not_ready) begin
      trk <= i_dir_n ? (trk > 0 ? trk - 1 : 0) : trk + 1;
      settle <= SETTLE;
    end else if (settle > 0) begin
      settle <= settle - 1;
    end
  end
  // Status pins; seek stays high while the heads settle
  assign o_seek_done_n = (settle != 0);
  assign o_outer_track_n = (trk != 0);
  assign o_ready_n = i_not_ready;
  assign o_write_fault_n = ~fault_q;
endmodule : ddsi_drive_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ====================
// Testbench top
module tb_top;
  import ddsi_pkg::*;
  logic i_sys_clk = '0, i_reset = '1, i_hsel = '0, i_hwrite = '0, i_host_init_n = '1;
  logic [7:0] i_haddr = '0;
  logic [1:0] i_htrans = '0;
  logic [2:0] i_hsize = '0;
  logic [31:0] i_hwdata = '0, o_hrdata, rd;
  logic o_hreadyout, o_hresp, o_irq, o_low_write_current_n, o_head_addr_bit0_n;
  logic o_head_addr_bit1_n, o_head_addr_bit2_n, o_write_gate_n, o_direction_n, o_step_n;
  logic i_seek_done_n, i_outer_track_n, i_ready_n, i_write_fault_n;
  logic bad_supply = '0, power_cycle = '0, not_ready = '0, step_q = '1, dir_seen;
  int fails = 0, n_compared = 0, cyc = 0, steps = 0, s0;
  wire i_hready = o_hreadyout;
  // Rows: write flag, address, data written or read value expected
  localparam logic [40:0] ROWS [13] = '{
    {1'b1, 8'h00, 32'h23}, {1'b0, 8'h00, 32'h23}, {1'b1, 8'h10, 32'hF}, {1'b0, 8'h10, 32'hF},
    {1'b1, 8'h40, 32'h55}, {1'b0, 8'h40, 32'h0}, {1'b1, 8'h14, 32'hA5}, {1'b1, 8'h14, 32'h5A},
    {1'b0, 8'h14, 32'hA5}, {1'b0, 8'h14, 32'h5A}, {1'b1, 8'h08, 32'hFF}, {1'b0, 8'h08, 32'h7},
    {1'b1, 8'h10, 32'h0}};
  ddsi_top i_ddsi_top (.*);
  ddsi_drive_model i_ddsi_drive_model (.i_sys_clk(i_sys_clk), .i_step_n(o_step_n),
    .i_dir_n(o_direction_n), .i_bad_supply(bad_supply), .i_power_cycle(power_cycle),
    .i_not_ready(not_ready), .o_seek_done_n(i_seek_done_n), .o_outer_track_n(i_outer_track_n),
    .o_ready_n(i_ready_n), .o_write_fault_n(i_write_fault_n));
  // Clock
  initial forever #25 i_sys_clk = ~i_sys_clk;
  // Step pulse counter and hang guard
  always @(posedge i_sys_clk) begin
    step_q <= o_step_n;
    if (step_q && !o_step_n) begin
      steps <= steps + 1;
      dir_seen <= o_direction_n;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single-word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_hsel <= 1'b1;
    i_htrans <= DDSI_HTRANS_NONSEQ;
    i_haddr <= a;
    i_hwrite <= w;
    i_hsize <= 3'h2;
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask : bus
  task automatic steps_of(input logic [31:0] cmd, input logic dir_n);
    s0 = steps;
    bus(1'b1, 8'h04, cmd);
    bus(1'b1, 8'h04, 32'h105);
    for (int k = 0; k < 2000 && o_irq !== 1'b1; k++) @(posedge i_sys_clk);
    chk(steps - s0, 2);
    chk(dir_seen, dir_n);
    bus(1'b1, 8'h0C, 32'hF);
    repeat (3) @(posedge i_sys_clk);
    chk(o_irq, 1'b0);
  endtask : steps_of
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence: table first, then the awkward cases
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    chk({o_step_n, o_write_gate_n, o_irq, o_head_addr_bit2_n}, 4'b1101);
    foreach (ROWS[i]) begin
      bus(ROWS[i][40], ROWS[i][39:32], ROWS[i][31:0]);
      if (!ROWS[i][40]) chk(rd, ROWS[i][31:0]);
    end
    bus(1'b1, 8'h00, 32'h32);
    repeat (8) @(posedge i_sys_clk);
    chk({o_head_addr_bit2_n, o_head_addr_bit1_n, o_head_addr_bit0_n,
         o_write_gate_n, o_low_write_current_n}, 5'b10100);
    bus(1'b1, 8'h00, 32'h17);
    repeat (8) @(posedge i_sys_clk);
    chk({o_head_addr_bit2_n, o_head_addr_bit1_n, o_head_addr_bit0_n,
         o_low_write_current_n}, 4'b1001);
    bad_supply <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    bad_supply <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk(o_write_gate_n, 1'b1);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'h4, 32'h4);
    power_cycle <= 1'b1;
    @(posedge i_sys_clk);
    power_cycle <= 1'b0;
    not_ready <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk(o_write_gate_n, 1'b1);
    not_ready <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk(o_write_gate_n, 1'b0);
    bus(1'b1, 8'h0C, 32'hF);
    bus(1'b1, 8'h10, 32'h1);
    steps_of(32'h102, 1'b0);
    steps_of(32'h002, 1'b1);
    repeat (30) @(posedge i_sys_clk);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h7);
    i_host_init_n <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_host_init_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk(o_write_gate_n, 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
